// *** testbench/asr_ctrl_tb_top.sv ***
// asr_ctrl_tb_top: self-checking bench for the static memory controller
`timescale 1ns/1ps
module asr_ctrl_tb_top;
  import asr_pkg::*;
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] exp;
  } asr_row_t;
  logic              i_clk, i_rst, i_req, i_we, i_sleep;
  logic [ADDR_W-1:0] i_addr, o_word_address_bus;
  logic [DATA_W-1:0] i_wdata, o_rdata, o_shared_data_bus, bus_w, dev_dq, float_q;
  logic              o_ready, o_rvalid, o_wdone, o_asleep, o_shared_data_bus_oe_n, dev_en;
  logic              o_select_low_active_n, o_select_high_active, o_write_strobe_n, o_output_enable_n;
  int                err_total, samples_checked, dev_faults, n;
  realtime           last_take;
  logic              last_rd;
  asr_row_t          rows [9];
  // ------------------------------------------------------------
  // design, memory model and the resolved data wire
  // ------------------------------------------------------------
  asr_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_wdone(o_wdone),
    .i_sleep(i_sleep), .o_asleep(o_asleep), .o_select_low_active_n(o_select_low_active_n),
    .o_select_high_active(o_select_high_active), .o_write_strobe_n(o_write_strobe_n),
    .o_output_enable_n(o_output_enable_n), .o_word_address_bus(o_word_address_bus),
    .i_shared_data_bus(bus_w), .o_shared_data_bus(o_shared_data_bus),
    .o_shared_data_bus_oe_n(o_shared_data_bus_oe_n));
  asr_mem_model mem_u (.i_select_low_active_n(o_select_low_active_n),
    .i_select_high_active(o_select_high_active), .i_write_strobe_n(o_write_strobe_n),
    .i_output_enable_n(o_output_enable_n), .i_word_address_bus(o_word_address_bus),
    .i_shared_data_bus(bus_w), .i_ctl_oe_n(o_shared_data_bus_oe_n), .o_dq(dev_dq),
    .o_dq_en(dev_en), .o_faults(dev_faults));
  // nobody drives: no pull, so show a pattern that flips every cycle
  assign bus_w = (o_shared_data_bus_oe_n === 1'b0) ? o_shared_data_bus : (dev_en ? dev_dq : float_q);
  always @(negedge i_clk) float_q <= ~float_q;
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------
  // checking, verdict and bus cycle tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // request held until taken, then pins watched cycle by cycle until the answer
  task automatic do_op(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [DATA_W-1:0] exp);
    int k;
    @(negedge i_clk);
    i_req = 1'b1;
    i_we = we;
    i_addr = a;
    i_wdata = d;
    k = 0;
    while (o_ready !== 1'b1 && k < 60) begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
    chk("take spacing", 1, ($realtime - last_take) >= (last_rd ? 100.0 : 80.0));
    last_take = $realtime;
    last_rd = !we;
    @(negedge i_clk);
    i_req = 1'b0;
    k = 1;
    while ((we ? o_wdone : o_rvalid) !== 1'b1 && k < 40) begin
      if (k == 5) begin
        chk("select low active", 0, o_select_low_active_n);
        chk("select high active", 1, o_select_high_active);
        chk("write strobe", !we, o_write_strobe_n);
        chk("bus drive", !we, o_shared_data_bus_oe_n);
        chk("address", a, o_word_address_bus);
        if (we) chk("write data", d, o_shared_data_bus);
        else chk("output enable", 0, o_output_enable_n);
      end
      if (k == 15 && we) begin
        chk("strobe released", 1, o_write_strobe_n);
        chk("select held", 0, o_select_low_active_n);
        chk("address held", a, o_word_address_bus);
        chk("data held", d, o_shared_data_bus);
      end
      @(negedge i_clk);
      k++;
    end
    chk("answer cycle", we ? 16 : 15, k);
    if (!we) chk("read data", exp, o_rdata);
    @(negedge i_clk);
    chk("answer pulse", 0, we ? o_wdone : o_rvalid);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {i_rst, i_req, i_we, i_sleep} = 4'b1000;
    i_addr = '0;
    i_wdata = '0;
    float_q = 8'h5a;
    {err_total, samples_checked} = 0;
    last_take = -1000.0;
    last_rd = 1'b0;
    rows = '{'{1'b1, 20'h00000, 8'ha5, 8'h00}, '{1'b1, 20'hfffff, 8'h5a, 8'h00},
             '{1'b0, 20'h00000, 8'h00, 8'ha5}, '{1'b0, 20'hfffff, 8'h00, 8'h5a},
             '{1'b1, 20'h12345, 8'hff, 8'h00}, '{1'b1, 20'h12345, 8'h00, 8'h00},
             '{1'b0, 20'h12345, 8'h00, 8'h00}, '{1'b1, 20'h80001, 8'hc3, 8'h00},
             '{1'b0, 20'h80001, 8'h00, 8'hc3}};
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    // idle pins: deselected, strobes high, bus released
    chk("reset select", 0, o_select_high_active);
    chk("reset strobe", 1, o_write_strobe_n);
    chk("reset enable", 1, o_output_enable_n);
    chk("reset drive", 1, o_shared_data_bus_oe_n);
    chk("reset ready", 1, o_ready);
    for (int i = 0; i < 9; i++) begin
      do_op(rows[i].we, rows[i].a, rows[i].d, rows[i].exp);
    end
    // retention: a write offered while asleep must be ignored
    @(negedge i_clk);
    i_sleep = 1'b1;
    // the read turnaround has to run out before retention is entered
    repeat (4) @(negedge i_clk);
    chk("asleep", 1, o_asleep);
    chk("asleep ready", 0, o_ready);
    chk("asleep high select", 0, o_select_high_active);
    chk("asleep low select", 1, o_select_low_active_n);
    i_req = 1'b1;
    i_we = 1'b1;
    i_addr = 20'h00000;
    i_wdata = 8'h77;
    repeat (4) @(negedge i_clk);
    i_req = 1'b0;
    i_sleep = 1'b0;
    n = 0;
    while (o_ready !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    chk("wake cycles", 1, n >= 14);
    do_op(1'b0, 20'h00000, 8'h00, 8'ha5);
    // reset in the middle of a read, held long enough for a full cycle
    @(negedge i_clk);
    i_req = 1'b1;
    i_we = 1'b0;
    i_addr = 20'hfffff;
    while (o_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    i_req = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("abort read live", 0, o_output_enable_n);
    i_rst = 1'b1;
    @(negedge i_clk);
    chk("abort select", 1, o_select_low_active_n);
    chk("abort enable", 1, o_output_enable_n);
    chk("abort answer", 0, o_rvalid);
    repeat (14) @(negedge i_clk);
    i_rst = 1'b0;
    do_op(1'b0, 20'hfffff, 8'h00, 8'h5a);
    repeat (10) @(negedge i_clk);
    chk("device timing faults", 0, dev_faults);
    close_out();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    close_out();
  end
endmodule

// *** testbench/asr_mem_model.sv ***
// asr_mem_model: behavioural static memory that answers the controller pins and tallies timing faults
`timescale 1ns/1ps
module asr_mem_model (
  // control pins
  input  wire logic                       i_select_low_active_n,
  input  wire logic                       i_select_high_active,
  input  wire logic                       i_write_strobe_n,
  input  wire logic                       i_output_enable_n,
  input  wire logic [asr_pkg::ADDR_W-1:0] i_word_address_bus,
  // resolved data wire and controller driver enable
  input  wire logic [asr_pkg::DATA_W-1:0] i_shared_data_bus,
  input  wire logic                       i_ctl_oe_n,
  // device drive and fault tally
  output logic      [asr_pkg::DATA_W-1:0] o_dq,
  output logic                            o_dq_en,
  output int                              o_faults
);
  import asr_pkg::*;
  // ------------------------------------------------------------
  // storage and pin decode
  // ------------------------------------------------------------
  localparam real OE_NS  = 40.0;
  localparam real OLZ_NS = 5.0;
  localparam real CLZ_NS = 10.0;
  logic [DATA_W-1:0] mem_q [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] din_q;
  logic              sel_q, wr_q, rd_q;
  realtime           t_addr = 0.0, t_din = 0.0, t_sel = 0.0, t_wr = 0.0, t_oe = 0.0, now;
  realtime           t_acc = -1000.0, t_off = -1000.0;
  // high-active select low alone deselects, whatever the other pins do
  wire sel = !i_select_low_active_n && i_select_high_active;
  wire wr  = sel && !i_write_strobe_n;
  wire rd  = sel && i_write_strobe_n && !i_output_enable_n;
  // ------------------------------------------------------------
  // pin watcher, polled a quarter nanosecond away from any clock edge
  // ------------------------------------------------------------
  initial begin
    o_faults = 0;
    o_dq = 8'h3c;
    o_dq_en = 1'b0;
    {sel_q, wr_q, rd_q} = 3'b000;
    addr_q = '0;
    din_q = '0;
    #0.25;
    forever begin
      #1;
      now = $realtime;
      if (i_word_address_bus !== addr_q) begin
        addr_q = i_word_address_bus;
        t_addr = now;
      end
      if (i_shared_data_bus !== din_q) begin
        din_q = i_shared_data_bus;
        t_din = now;
      end
      if (sel && !sel_q) begin
        if (now - t_acc < T_RC_NS) o_faults++;
        t_acc = now;
        t_sel = now;
      end
      if (wr && !wr_q) t_wr = now;
      // first releasing edge ends the write; data is judged against it
      if (!wr && wr_q) begin
        if (now - t_wr < T_WP_NS || now - t_addr < T_AW_NS || t_addr > t_wr ||
            now - t_sel < T_CW_NS || now - t_din < T_DW_NS) begin
          o_faults++;
        end else begin
          mem_q[addr_q] = din_q;
        end
      end
      if (rd && !rd_q) t_oe = now;
      if (!rd && rd_q) t_off = now;
      // worst case everywhere: late valid data, garbage until then, slowest release
      if (rd && now - t_oe >= OLZ_NS && now - t_sel >= CLZ_NS) begin
        o_dq_en = 1'b1;
        // a pin change is noticed up to one poll step late, so that step is credited back on the address and select access times
        if (now - t_addr >= T_AA_NS - 1 && now - t_sel >= T_AA_NS - 1 && now - t_oe >= OE_NS) begin
          o_dq = mem_q.exists(addr_q) ? mem_q[addr_q] : ~addr_q[DATA_W-1:0];
        end else begin
          o_dq = ~o_dq;
        end
      end else if (!rd && now - t_off < T_HZ_NS) begin
        o_dq_en = 1'b1;
        o_dq = ~o_dq;
      end else begin
        o_dq_en = 1'b0;
      end
      if (o_dq_en && i_ctl_oe_n === 1'b0) o_faults++;
      sel_q = sel;
      wr_q = wr;
      rd_q = rd;
    end
  end
endmodule

// *** verilog/asr_bus_pins.sv ***
// asr_bus_pins: registered drivers and read capture for the shared data bus
`timescale 1ns/1ps
module asr_bus_pins (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // control from the sequencer
  input  wire logic                       i_drive,
  input  wire logic                       i_capture,
  input  wire logic [asr_pkg::DATA_W-1:0] i_wdata,
  // pins
  input  wire logic [asr_pkg::DATA_W-1:0] i_pin,
  output logic      [asr_pkg::DATA_W-1:0] o_pin,
  output logic                            o_pin_oe_n,
  // captured read data
  output logic      [asr_pkg::DATA_W-1:0] o_rdata
);
  import asr_pkg::*;

  logic [DATA_W-1:0] out_q;
  logic              oe_n_q;
  logic [DATA_W-1:0] rd_q;

  // drivers are registered so the enable and data switch on the same edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_q  <= '0;
      oe_n_q <= 1'b1;
      rd_q   <= '0;
    end else begin
      out_q  <= i_drive ? i_wdata : out_q;
      oe_n_q <= ~i_drive;
      rd_q   <= i_capture ? i_pin : rd_q;
    end
  end

  assign o_pin      = out_q;
  assign o_pin_oe_n = oe_n_q;
  assign o_rdata    = rd_q;

endmodule

// *** verilog/asr_ctrl.sv ***
// asr_ctrl: host-side sequencer that runs read, write and retention cycles on the static memory pins
// Functional notes
// RQ1: memory holds 1M bytes, 20-bit address.
// RQ2: device drives data only when reading.
// RQ3: write needs both selects active, strobe low.
// RQ4: write starts at last asserting edge.
// RQ5: write ends at first releasing edge.
// RQ6: read data valid 70 ns after address.
// RQ7: read data valid 70 ns after selection.
// RQ8: read data valid 40 ns after output enable.
// RQ9: outputs float 25 ns after deselect.
// RQ10: outputs float 25 ns after enable release.
// RQ11: write pulse at least 50 ns.
// RQ12: address valid 60 ns before write end.
// RQ13: selects active 60 ns before write end.
// RQ14: address valid by write start.
// RQ15: address held until write end.
// RQ16: write data stable 30 ns before end.
// RQ17: write data held until write end.
// RQ18: strobe low floats device outputs.
// RQ19: release bus soon after write end.
// RQ20: each cycle lasts at least 70 ns.
// RQ21: retention held by high-active select low.
// RQ22: deselect first, wait cycle time after.
// RQ23: strobe high in reads, no bus contention.
`timescale 1ns/1ps
module asr_ctrl (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // user request port
  input  wire logic                       i_req,
  input  wire logic                       i_we,
  input  wire logic [asr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [asr_pkg::DATA_W-1:0] i_wdata,
  output logic                            o_ready,
  // user answers
  output logic      [asr_pkg::DATA_W-1:0] o_rdata,
  output logic                            o_rvalid,
  output logic                            o_wdone,
  // retention request and status
  input  wire logic                       i_sleep,
  output logic                            o_asleep,
  // memory control pins
  output logic                            o_select_low_active_n,
  output logic                            o_select_high_active,
  output logic                            o_write_strobe_n,
  output logic                            o_output_enable_n,
  output logic      [asr_pkg::ADDR_W-1:0] o_word_address_bus,
  // memory data pins
  input  wire logic [asr_pkg::DATA_W-1:0] i_shared_data_bus,
  output logic      [asr_pkg::DATA_W-1:0] o_shared_data_bus,
  output logic                            o_shared_data_bus_oe_n
);
  import asr_pkg::*;

  // ----------------------------------------------------------------
  // state and request holding registers
  // ----------------------------------------------------------------
  asr_state_t        state_q;
  asr_state_t        state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              sel_n_q;
  logic              sel_hi_q;
  logic              we_n_q;
  logic              oe_n_q;
  logic              rvalid_q;
  logic              wdone_q;

  logic              tmr_done;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_count;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire take       = (state_q == ST_IDLE) && !i_sleep && i_req;
  wire rd_end     = (state_q == ST_READ) && tmr_done;
  wire wr_end     = (state_q == ST_WRITE) && tmr_done;
  wire hold_end   = (state_q == ST_WR_HOLD);
  wire turn_end   = (state_q == ST_RD_TURN) && tmr_done;
  wire wake_end   = (state_q == ST_WAKE) && tmr_done;
  wire go_sleep   = (state_q == ST_IDLE) && i_sleep;
  wire leave_slp  = (state_q == ST_SLEEP) && !i_sleep;

  // pin levels follow the next state so pins and state change on one edge
  wire nx_sel     = (state_d == ST_READ) || (state_d == ST_WRITE) || (state_d == ST_WR_HOLD);
  wire nx_we      = (state_d == ST_WRITE);                                 // RQ3
  wire nx_oe      = (state_d == ST_READ);                                  // RQ23
  wire nx_drive   = (state_d == ST_WRITE) || (state_d == ST_WR_HOLD);      // RQ17

  // timer reload on entry to read, write, turnaround and wake; phase lasts count plus one cycles
  assign tmr_load  = take || rd_end || leave_slp;
  assign tmr_count = take ? (i_we ? WR_CYC - 5'h01 : RD_CYC - 5'h01) :     // RQ11 RQ20
                     rd_end ? HZ_CYC - 5'h01 :                             // RQ10 RQ9
                     REC_CYC - 5'h01;                                      // RQ22

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go_sleep) begin
          state_d = ST_SLEEP;                                              // RQ22
        end else if (take) begin
          state_d = i_we ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        if (rd_end) begin
          state_d = ST_RD_TURN;                                            // RQ6 RQ7 RQ8
        end
      end
      ST_RD_TURN: begin
        // bus stays undriven until the device has floated its outputs
        if (turn_end) begin
          state_d = ST_IDLE;                                               // RQ23
        end
      end
      ST_WRITE: begin
        if (wr_end) begin
          state_d = ST_WR_HOLD;                                            // RQ5
        end
      end
      ST_WR_HOLD: begin
        state_d = ST_IDLE;                                                 // RQ15
      end
      ST_SLEEP: begin
        if (!i_sleep) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_end) begin
          state_d = ST_IDLE;                                               // RQ22
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // address and data latched at acceptance, held for the whole cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (take) begin
      addr_q  <= i_addr;                                                   // RQ14 RQ12
      wdata_q <= i_wdata;                                                  // RQ16
    end
  end

  // control pins, all registered to avoid glitches on the strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_n_q  <= 1'b1;
      sel_hi_q <= 1'b0;
      we_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
    end else begin
      sel_n_q  <= ~nx_sel;                                                 // RQ13
      sel_hi_q <= nx_sel;                                                  // RQ21
      we_n_q   <= ~nx_we;                                                  // RQ4
      oe_n_q   <= ~nx_oe;                                                  // RQ2
    end
  end

  // one-cycle completion pulses
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      wdone_q  <= 1'b0;
    end else begin
      rvalid_q <= rd_end;
      wdone_q  <= hold_end;
    end
  end

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  asr_timer u_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  // the write strobe floats the device, and output enable is already high
  asr_bus_pins u_pins (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_drive    (nx_drive),                                                // RQ18 RQ19
    .i_capture  (rd_end),
    .i_wdata    (wdata_q),
    .i_pin      (i_shared_data_bus),
    .o_pin      (o_shared_data_bus),
    .o_pin_oe_n (o_shared_data_bus_oe_n),
    .o_rdata    (o_rdata)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_ready               = (state_q == ST_IDLE) && !i_sleep;
  assign o_rvalid              = rvalid_q;
  assign o_wdone               = wdone_q;
  assign o_asleep              = (state_q == ST_SLEEP);
  assign o_select_low_active_n = sel_n_q;
  assign o_select_high_active  = sel_hi_q;                                 // RQ21
  assign o_write_strobe_n      = we_n_q;
  assign o_output_enable_n     = oe_n_q;
  assign o_word_address_bus    = addr_q;                                   // RQ1

  // ----------------------------------------------------------------
  // checking helpers: run lengths of pin conditions
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] we_low_q;
  logic [CNT_W-1:0] sel_on_q;
  logic [CNT_W-1:0] dat_stb_q;
  logic [CNT_W-1:0] oe_low_q;
  logic [CNT_W-1:0] oe_high_q;
  logic [CNT_W-1:0] wake_q;
  logic [DATA_W-1:0] dat_prev_q;

  wire sel_on  = !o_select_low_active_n && o_select_high_active;
  wire dat_on  = !o_shared_data_bus_oe_n && (o_shared_data_bus == dat_prev_q);

  // saturating counts cover the cycles before the current one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      we_low_q   <= '0;
      sel_on_q   <= '0;
      dat_stb_q  <= '0;
      oe_low_q   <= '0;
      oe_high_q  <= CNT_MAX;
      wake_q     <= CNT_MAX;
      dat_prev_q <= '0;
    end else begin
      we_low_q   <= !o_write_strobe_n ? ((we_low_q == CNT_MAX) ? we_low_q : we_low_q + 5'h01) : '0;
      sel_on_q   <= sel_on ? ((sel_on_q == CNT_MAX) ? sel_on_q : sel_on_q + 5'h01) : '0;
      dat_stb_q  <= dat_on ? ((dat_stb_q == CNT_MAX) ? dat_stb_q : dat_stb_q + 5'h01) : '0;
      oe_low_q   <= !o_output_enable_n ? ((oe_low_q == CNT_MAX) ? oe_low_q : oe_low_q + 5'h01) : '0;
      oe_high_q  <= o_output_enable_n ? ((oe_high_q == CNT_MAX) ? oe_high_q : oe_high_q + 5'h01) : '0;
      wake_q     <= o_asleep ? '0 : ((wake_q == CNT_MAX) ? wake_q : wake_q + 5'h01);
      dat_prev_q <= o_shared_data_bus;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wr_pulse_width_a: assert property ($rose(o_write_strobe_n) |-> we_low_q >= WR_CYC) // RQ11
    else $error("write pulse shorter than required");
  wr_select_held_a: assert property (!o_write_strobe_n |-> sel_on) // RQ3
    else $error("write strobe low while chip not selected");
  wr_select_time_a: assert property ($rose(o_write_strobe_n) |-> sel_on_q >= CW_CYC) // RQ13
    else $error("selection too short before end of write");
  wr_addr_stable_a: assert property (!o_write_strobe_n ##1 1'b1 |-> $stable(o_word_address_bus)) // RQ12
    else $error("address moved during or at end of write");
  wr_data_setup_a: assert property ($rose(o_write_strobe_n) |-> dat_stb_q >= DW_CYC) // RQ16
    else $error("write data setup too short");
  wr_data_hold_a: assert property ($rose(o_write_strobe_n) |-> !o_shared_data_bus_oe_n
                                   ##1 (o_shared_data_bus_oe_n && o_select_low_active_n)) // RQ17
    else $error("write data not held through end of write");
  wr_start_addr_a: assert property ($fell(o_write_strobe_n) |-> $fell(o_select_low_active_n)
                                    && $changed(o_word_address_bus) || $stable(o_word_address_bus)) // RQ14
    else $error("write started before address was set");
  rd_strobe_high_a: assert property (!o_output_enable_n |-> o_write_strobe_n && o_shared_data_bus_oe_n) // RQ23
    else $error("strobe or drivers active during read");
  rd_access_time_a: assert property (o_rvalid |-> $past(oe_low_q) >= RD_CYC - 5'h01) // RQ6
    else $error("read data sampled before access time");
  bus_turnaround_a: assert property ($fell(o_shared_data_bus_oe_n) |-> $past(oe_high_q) >= HZ_CYC) // RQ10
    else $error("bus driven before device outputs floated");
  sleep_deselect_a: assert property (o_asleep |-> !o_select_high_active && o_select_low_active_n
                                     && o_shared_data_bus_oe_n) // RQ21
    else $error("retention entered while selected or driving");
  wake_recovery_a: assert property ($fell(o_select_low_active_n) |-> $past(wake_q) >= REC_CYC) // RQ22
    else $error("access started too soon after retention");

  rd_done_c: cover property (o_rvalid);
  wr_done_c: cover property (o_wdone);
  sleep_wake_c: cover property ($fell(o_asleep) ##[1:40] o_ready);
  rd_then_wr_c: cover property (o_rvalid ##[1:20] $fell(o_write_strobe_n));

endmodule

// *** verilog/asr_pkg.sv ***
// asr_pkg: shared widths, pin timing figures and state codes for the memory controller
package asr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 5;

  // ----------------------------------------------------------------
  // timing in ns (slower grade, which also meets the faster grade)
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 5;   // 200 MHz
  localparam int T_RC_NS   = 70;  // read cycle time
  localparam int T_AA_NS   = 70;  // address / select access time
  localparam int T_WC_NS   = 70;  // write cycle time
  localparam int T_WP_NS   = 50;  // write pulse width
  localparam int T_CW_NS   = 60;  // selection to end of write
  localparam int T_AW_NS   = 60;  // address valid to end of write
  localparam int T_DW_NS   = 30;  // data to end of write
  localparam int T_HZ_NS   = 25;  // output float after deselect or output disable
  localparam int T_R_NS    = T_RC_NS;  // recovery after retention

  // least times round up to whole cycles
  localparam int WR_NS     = (T_WC_NS > T_AW_NS) ? T_WC_NS : T_AW_NS;
  localparam int RD_CYC_I  = (T_AA_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC_I  = (WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC_I  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW_CYC_I  = (T_CW_NS + CLK_NS - 1) / CLK_NS;
  localparam int DW_CYC_I  = (T_DW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HZ_CYC_I  = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC_I = (T_R_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(RD_CYC_I);
  localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(WR_CYC_I);
  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'(WP_CYC_I);
  localparam logic [CNT_W-1:0] CW_CYC  = CNT_W'(CW_CYC_I);
  localparam logic [CNT_W-1:0] DW_CYC  = CNT_W'(DW_CYC_I);
  localparam logic [CNT_W-1:0] HZ_CYC  = CNT_W'(HZ_CYC_I);
  localparam logic [CNT_W-1:0] REC_CYC = CNT_W'(REC_CYC_I);
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_RD_TURN = 3'b010,
    ST_WRITE   = 3'b011,
    ST_WR_HOLD = 3'b100,
    ST_SLEEP   = 3'b101,
    ST_WAKE    = 3'b110
  } asr_state_t;

endpackage

// *** verilog/asr_timer.sv ***
// asr_timer: loadable down counter that times the read, write, turnaround and wake phases
`timescale 1ns/1ps
module asr_timer (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // load and status
  input  wire logic                      i_load,
  input  wire logic [asr_pkg::CNT_W-1:0] i_count,
  output logic                           o_done
);
  import asr_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // count down to zero and stay there until reloaded
  assign cnt_d  = i_load ? i_count : ((cnt_q != '0) ? cnt_q - 5'h01 : cnt_q);
  assign o_done = (cnt_q == '0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
